// [idx_decode_cfg.svh]
// Overview of operation
// - Operand at or below 5Fh offsets pointer
// - Indexing only when access bit zero
// - Decode 0010 01d0 as indexed add
// - Destination bit picks working register or byte
// - Decode 1000 bbb0 as indexed bit set
// - Decode 0110 1000 as fill with FFh
// - Extension active only when fuse is one
`ifndef IDX_DECODE_CFG_SVH
`define IDX_DECODE_CFG_SVH
// ------------------------------------------------------------
// Opcode fields and limits
// ------------------------------------------------------------
`define OFFSET_LIMIT 8'h5F
`define OP_ADD_HI 6'h09
`define OP_BIT_HI 4'h8
`define OP_FILL_HI 8'h68
`define FILL_VALUE 8'hFF
`define ACC_BIT 8
`define DST_BIT 9
`define ACCESS_SFR_BASE 12'hF00
`endif

// [idx_decode_pkg.sv]
package idx_decode_pkg;
    // Request from the fetch stage
    typedef struct packed
    {
        logic valid;
        logic [15:0] word;
    } instr_t;
    // Write issued to the data memory
    typedef struct packed
    {
        logic en;
        logic [11:0] addr;
        logic [7:0] data;
    } mem_wr_t;
    // Arithmetic flags: negative, overflow, zero, digit carry, carry
    typedef struct packed
    {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_t;
    // Decoded operation kinds
    typedef enum logic [3:0]
    {
        OP_NONE = 4'h1,
        OP_ADD = 4'h2,
        OP_BIT = 4'h4,
        OP_FILL = 4'h8
    } op_t;
endpackage

// [idx_alu.sv]
`timescale 1ns/10ps
`include "idx_decode_cfg.svh"
// Byte adder with the full flag set
module idx_alu
(
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // Result
    output logic [7:0] sum,
    output idx_decode_pkg::flags_t flags
);
    import idx_decode_pkg::*;
    logic [8:0] wide; // Sum with carry out
    logic [4:0] low; // Low nibble sum for digit carry
    // ------------------------------------------------------------
    // Sum and flags
    // ------------------------------------------------------------
    always_comb
    begin
        wide = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum = wide[7:0];
        flags.c = wide[8];
        flags.dc = low[4];
        flags.z = (wide[7:0] == 8'h00);
        flags.n = wide[7];
        // Signed overflow: like-signed inputs giving opposite sign
        flags.ov = (a[7] == b[7]) && (wide[7] != a[7]);
    end
endmodule

// [indexed_offset_decode.sv]
`timescale 1ns/10ps
`include "idx_decode_cfg.svh"
// Indexed literal offset executor: one instruction per enabled cycle
module indexed_offset_decode
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic INSTR_CLK_EN,
    // Configuration fuse level, quasi static
    input wire logic EXTENSION_ENABLE_FUSE,
    // Instruction and core state
    input idx_decode_pkg::instr_t INSTR,
    input wire logic [11:0] THIRD_INDIRECT_POINTER,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [7:0] WREG_IN,
    // Data memory read port, asynchronous read
    output logic [11:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    // Results
    output idx_decode_pkg::mem_wr_t MEM_WR,
    output logic WREG_WE,
    output logic [7:0] WREG_OUT,
    output logic FLAGS_WE,
    output idx_decode_pkg::flags_t FLAGS_OUT,
    output logic HANDLED
);
    import idx_decode_pkg::*;

    // ------------------------------------------------------------
    // Fuse capture
    // ------------------------------------------------------------
    logic fuse_s1_q; // First stage, read only by the second
    logic fuse_q; // Synchronised fuse level
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            fuse_s1_q <= 1'b0;
            fuse_q <= 1'b0;
        end
        else
        begin
            fuse_s1_q <= EXTENSION_ENABLE_FUSE;
            fuse_q <= fuse_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    op_t op; // Operation for this word
    logic indexed; // Operand taken as pointer offset
    logic [7:0] fld; // Low byte of opcode
    logic [11:0] ea; // Effective data address
    // Effective address for an operand
    function automatic logic [11:0] eff_addr(input logic ext, input logic acc,
        input logic [7:0] f, input logic [11:0] ptr, input logic [3:0] bank_select_register);
        if (!acc && ext && f <= `OFFSET_LIMIT)
            return ptr + {4'h0, f};
        else if (acc)
            return {bank_select_register, f};
        else if (f <= `OFFSET_LIMIT)
            return {4'h0, f};
        else
            return `ACCESS_SFR_BASE | {4'h0, f};
    endfunction
    always_comb
    begin
        fld = INSTR.word[7:0];
        op = OP_NONE;
        // Extension off: nothing here executes
        // fuse gate
        if (INSTR.valid && fuse_q)
        begin
            if (INSTR.word[15:10] == `OP_ADD_HI && !INSTR.word[`ACC_BIT])
                op = OP_ADD;
            else if (INSTR.word[15:12] == `OP_BIT_HI && !INSTR.word[`ACC_BIT])
                op = OP_BIT;
            else if (INSTR.word[15:8] == `OP_FILL_HI)
                op = OP_FILL;
            else
                op = OP_NONE;
        end
        indexed = (op != OP_NONE) && (fld <= `OFFSET_LIMIT);
        ea = eff_addr(fuse_q, INSTR.word[`ACC_BIT], fld, THIRD_INDIRECT_POINTER,
            BANK_SELECT_REGISTER);
    end
    // Above 5Fh the operand stays literal; the core handles those forms
    assign RD_ADDR = ea;
    assign HANDLED = indexed && INSTR_CLK_EN;

    // ------------------------------------------------------------
    // Process
    // ------------------------------------------------------------
    logic [7:0] sum;
    flags_t fl;
    idx_alu u_alu
    (
        .a(WREG_IN),
        .b(RD_DATA),
        .sum(sum),
        .flags(fl)
    );
    logic [7:0] bit_mask; // One-hot mask for the bit set
    assign bit_mask = 8'h01 << INSTR.word[11:9];

    // ------------------------------------------------------------
    // Write back, one cycle per instruction
    // ------------------------------------------------------------
    // single cycle
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            MEM_WR <= '0;
            WREG_WE <= 1'b0;
            WREG_OUT <= 8'h00;
            FLAGS_WE <= 1'b0;
            FLAGS_OUT <= '0;
        end
        else
        begin
            MEM_WR.en <= 1'b0;
            WREG_WE <= 1'b0;
            FLAGS_WE <= 1'b0;
            if (indexed && INSTR_CLK_EN)
            begin
                MEM_WR.addr <= ea;
                case (op)
                    OP_ADD:
                    begin
                        MEM_WR.en <= INSTR.word[`DST_BIT];
                        MEM_WR.data <= sum;
                        WREG_WE <= !INSTR.word[`DST_BIT];
                        WREG_OUT <= sum;
                        FLAGS_WE <= 1'b1;
                        FLAGS_OUT <= fl;
                    end
                    OP_BIT:
                    begin
                        MEM_WR.en <= 1'b1;
                        MEM_WR.data <= RD_DATA | bit_mask;
                    end
                    OP_FILL:
                    begin
                        MEM_WR.en <= 1'b1;
                        MEM_WR.data <= `FILL_VALUE;
                    end
                    default:
                    begin
                        MEM_WR.en <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// [idx_properties.sv]
`timescale 1ns/10ps
module idx_properties
import idx_decode_pkg::*;
(
    // Watched ports
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic EXTENSION_ENABLE_FUSE,
    input instr_t INSTR,
    input wire logic [11:0] THIRD_INDIRECT_POINTER,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [7:0] WREG_IN,
    input wire logic [11:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    input mem_wr_t MEM_WR,
    input wire logic WREG_WE,
    input wire logic [7:0] WREG_OUT,
    input wire logic FLAGS_WE,
    input wire logic HANDLED
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    // Opcode classes; the fill form carries a zero access bit in its code
    wire add = INSTR.word[15:10] == 6'h09;
    wire bits = INSTR.word[15:12] == 4'h8;
    wire fill = INSTR.word[15:8] == 8'h68;
    // Byte write with flags left alone
    sequence s_mem;
        MEM_WR.en && !FLAGS_WE;
    endsequence
    eff_addr_a: assert property (HANDLED |-> RD_ADDR == THIRD_INDIRECT_POINTER + {4'h0, INSTR.word[7:0]})
        else $error("bad address");
    access_bit_a: assert property (HANDLED |-> !INSTR.word[8] && INSTR.word[7:0] <= 8'h5F)
        else $error("bad take");
    bank_addr_a: assert property (INSTR.word[8] |-> RD_ADDR == {BANK_SELECT_REGISTER, INSTR.word[7:0]})
        else $error("bank address");
    add_flags_a: assert property (HANDLED && add |=> FLAGS_WE && WREG_WE != MEM_WR.en)
        else $error("add flags");
    add_dest_a: assert property (HANDLED && add |=> WREG_WE == !$past(INSTR.word[9])
        && (WREG_WE ? WREG_OUT : MEM_WR.data) == 8'($past(WREG_IN) + $past(RD_DATA)))
        else $error("add result");
    bit_set_a: assert property (HANDLED && bits |=> s_mem ##0
        MEM_WR.data == ($past(RD_DATA) | (8'h01 << $past(INSTR.word[11:9]))))
        else $error("bit set");
    fill_ones_a: assert property (HANDLED && fill |=> s_mem ##0 MEM_WR.data == 8'hFF)
        else $error("fill");
    fuse_off_a: assert property (!EXTENSION_ENABLE_FUSE [*3] |-> !HANDLED)
        else $error("fuse off");
    one_cycle_a: assert property (!HANDLED |=> !MEM_WR.en && !WREG_WE && !FLAGS_WE)
        else $error("stray write");
endmodule
bind indexed_offset_decode idx_properties idx_properties_inst (.SYS_CLK, .RESET,
    .EXTENSION_ENABLE_FUSE, .INSTR, .THIRD_INDIRECT_POINTER, .BANK_SELECT_REGISTER,
    .WREG_IN, .RD_ADDR,
    .RD_DATA, .MEM_WR, .WREG_WE, .WREG_OUT, .FLAGS_WE, .HANDLED);

// [indexed_offset_decode_tb.sv]
`timescale 1ns/10ps
module indexed_offset_decode_tb;
    import idx_decode_pkg::*;
    logic clk = 0, rst = 1, en = 0, fuse = 0, wwe, fwe, hnd;
    instr_t ins = '0;
    mem_wr_t mw;
    flags_t fl;
    logic [11:0] ptr = 12'h000, ra;
    logic [7:0] wr = 8'h00, wout, rd;
    logic [15:0] w;
    logic [31:0] seed = 32'hBBAA;
    logic [20:0] q[$];
    logic [4:0] fq[$];
    logic [3:0] bank_select_register = 4'h3;
    int errors = 0, tests_run = 0, k;
    always #25 clk = ~clk;
    // Memory contents follow the address
    assign rd = ra[7:0] ^ 8'h5A;
    indexed_offset_decode indexed_offset_decode_inst (.SYS_CLK(clk), .RESET(rst),
        .INSTR_CLK_EN(en), .EXTENSION_ENABLE_FUSE(fuse), .INSTR(ins),
        .THIRD_INDIRECT_POINTER(ptr), .BANK_SELECT_REGISTER(bank_select_register), .WREG_IN(wr),
        .RD_ADDR(ra), .RD_DATA(rd), .MEM_WR(mw), .WREG_WE(wwe), .WREG_OUT(wout),
        .FLAGS_WE(fwe), .FLAGS_OUT(fl), .HANDLED(hnd));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task print_verdict;
        errors += q.size() + fq.size();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Oldest note against what appeared
    task chk(input logic [20:0] got);
        tests_run++;
        if (q.size() == 0 || q[0] !== got)
            begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, q.size() ? q[0] : 21'h0, got);
            end
        if (q.size())
            void'(q.pop_front());
    endtask
    // Oldest flag note against the flags that appeared
    task chk_flags(input logic [4:0] got);
        tests_run++;
        if (fq.size() == 0 || fq[0] !== got)
            begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, fq.size() ? fq[0] : 5'h0, got);
            end
        if (fq.size())
            void'(fq.pop_front());
    endtask
    always @(posedge clk)
    begin
        #1;
        if (fwe === 1'b1)
            chk_flags(fl);
        if (mw.en === 1'b1)
            chk({1'b1, mw.addr, mw.data});
        if (wwe === 1'b1)
            chk({1'b0, 12'h000, wout});
    end
    // One instruction, note expected result
    task op(input logic [15:0] w, input logic e, input logic v);
        logic [11:0] a;
        logic [7:0] d;
        logic [8:0] s9;
        logic [4:0] s5;
        @(negedge clk);
        ptr = 12'(rnd());
        bank_select_register = 4'(rnd());
        wr = 8'(rnd());
        en = e;
        ins = '{v, w};
        a = ptr + {4'h0, w[7:0]};
        d = a[7:0] ^ 8'h5A;
        if (e && v && fuse && w[7:0] <= 8'h5F && !w[8])
            begin
            if (w[15:12] == 4'h8)
                q.push_back({1'b1, a, d | (8'h01 << w[11:9])});
            else if (w[15:8] == 8'h68)
                q.push_back({1'b1, a, 8'hFF});
            else if (w[15:10] == 6'h09)
                begin
                q.push_back({w[9] ? {1'b1, a} : 13'h0, 8'(d + wr)});
                s9 = {1'b0, d} + {1'b0, wr};
                s5 = {1'b0, d[3:0]} + {1'b0, wr[3:0]};
                fq.push_back({s9[7], (d[7] == wr[7]) && (s9[7] != wr[7]), s9[7:0] == 8'h00,
                    s5[4], s9[8]});
                end
            end
    endtask
    initial
    begin
        #100000;
        errors++;
        print_verdict;
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 0;
        for (int p = 0; p < 3; p++)
            begin
            en = 0;
            fuse = (p != 1);
            repeat (3) @(negedge clk);
            op(16'h242C, 1, 1);
            op(16'h8E5F, 1, 1);
            op(16'h6860, 1, 1);
            for (int i = 0; i < 100; i++)
                begin
                w = 16'(rnd());
                k = rnd() % 4;
                if (k == 0)
                    w[15:10] = 6'h09;
                else if (k == 1)
                    w[15:12] = 4'h8;
                else if (k == 2)
                    w[15:9] = 7'h34;
                w[7:0] = 8'(rnd() % 112);
                op(w, rnd() % 8 != 0, rnd() % 16 != 0);
                end
            end
        repeat (3) @(negedge clk);
        print_verdict;
    end
endmodule
